/* File: hdl/twcrl_pkg.sv */
package twcrl_pkg;
   // ****************************************
   // frame layout
   // ****************************************
   localparam int FRAME_BITS = 24;
   localparam int ADDR_BITS = 4;
   localparam int DATA_BITS = 20;
   localparam logic [4:0] FRAME_LAST = 5'h17;
   // ****************************************
   // register addresses
   // ****************************************
   localparam logic [3:0] ADDR_MAIN_DIV = 4'h2;
   localparam logic [3:0] ADDR_REF_DIV = 4'h3;
   localparam logic [3:0] ADDR_OP_CTRL = 4'h4;
   localparam logic [3:0] ADDR_SETUP = 4'h5;
   localparam logic [3:0] ADDR_TEST = 4'h7;
   // ****************************************
   // widths and power-up values
   // ****************************************
   localparam int MAIN_W = 14;
   localparam int REF_W = 11;
   localparam int OPC_W = 16;
   localparam int SETUP_W = 16;
   localparam int TEST_W = 8;
   localparam logic [13:0] MAIN_RST = 14'h1977;
   localparam logic [10:0] REF_RST = 11'h1ec;
   localparam logic [15:0] OPC_RST = 16'h892f;
   localparam logic [15:0] SETUP_RST = 16'hd03f;
   localparam logic [7:0] TEST_RST = 8'h00;
   // ****************************************
   // operation control fields
   // ****************************************
   localparam int OPC_SOFT_PD = 0;
   localparam int OPC_TX_IDLE = 1;
   localparam int OPC_STANDBY_KEEP_REGS_N = 2;
   localparam int OPC_CP_BOOST = 13;
endpackage

/* File: hdl/twcrl_loader.sv */
`timescale 1ns/1ps
`default_nettype none
module twcrl_loader (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdata,
   input wire logic shutdown_pin_n,
   output logic [twcrl_pkg::MAIN_W-1:0] if_main_divide_ratio,
   output logic [twcrl_pkg::REF_W-1:0] if_reference_divide_ratio,
   output logic [twcrl_pkg::OPC_W-1:0] operation_control,
   output logic [twcrl_pkg::SETUP_W-1:0] pll_and_input_setup,
   output logic [twcrl_pkg::TEST_W-1:0] test_mode_control,
   output logic charge_pump_boost,
   output logic core_enable,
   output logic pll_enable,
   output logic transmit_enable,
   output logic frame_error
);
   import twcrl_pkg::*;

   // ****************************************
   // link domain: shifter on serial clock
   // ****************************************
   // async-clear from the shutdown pin kills the interface itself
   logic link_rst_n;
   assign link_rst_n = rst_n & shutdown_pin_n;
   logic [FRAME_BITS-1:0] shift_r;
   logic [4:0] count_r;

   always_ff @(posedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         shift_r <= '0;
      end else if (!cs_n) begin
         shift_r <= {shift_r[FRAME_BITS-2:0], sdata};
      end
   end

   // the count must survive cs_n going high, because the bank reads it a few
   // mclk edges later; a flag cleared by cs_n high restarts it on the first bit
   logic frame_open_r;
   logic open_clr_n;
   assign open_clr_n = link_rst_n & ~cs_n;
   always_ff @(posedge sclk or negedge open_clr_n) begin
      if (!open_clr_n) begin
         frame_open_r <= 1'b0;
      end else begin
         frame_open_r <= 1'b1;
      end
   end

   // saturates so an overlong frame still reads as full
   always_ff @(posedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         count_r <= '0;
      end else if (!cs_n) begin
         if (!frame_open_r) begin
            count_r <= 5'h01;
         end else if (count_r != 5'h1f) begin
            count_r <= count_r + 5'h01;
         end
      end
   end

   // ****************************************
   // crossing: cs_n level into mclk domain
   // ****************************************
   // shift_r is stable while cs_n is high (sclk frames only in cs_n low),
   // so it is sampled once the synchronised high level is seen
   logic cs_s1_r, cs_s2_r, cs_s3_r;
   logic pin_s1_r, pin_s2_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cs_s1_r <= 1'b1;
         cs_s2_r <= 1'b1;
         cs_s3_r <= 1'b1;
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
      end else begin
         cs_s1_r <= cs_n;
         cs_s2_r <= cs_s1_r;
         cs_s3_r <= cs_s2_r;
         pin_s1_r <= shutdown_pin_n;
         pin_s2_r <= pin_s1_r;
      end
   end

   logic cs_rise;
   assign cs_rise = cs_s2_r & ~cs_s3_r;

   logic [3:0] f_addr;
   logic [DATA_BITS-1:0] f_data;
   logic f_full;
   assign f_addr = shift_r[ADDR_BITS-1:0];
   assign f_data = shift_r[FRAME_BITS-1:ADDR_BITS];
   // short frames are dropped; long frames keep the last 24 bits
   assign f_full = (count_r >= 5'(FRAME_BITS));

   // any address outside the five registers is dropped and flagged
   logic undef_addr;
   assign undef_addr = !(f_addr inside {ADDR_MAIN_DIV, ADDR_REF_DIV, ADDR_OP_CTRL,
                                        ADDR_SETUP, ADDR_TEST});

   // ****************************************
   // register bank
   // ****************************************
   logic [MAIN_W-1:0] main_r;
   logic [REF_W-1:0] ref_r;
   logic [OPC_W-1:0] opc_r;
   logic [SETUP_W-1:0] setup_r;
   logic [TEST_W-1:0] test_r;
   logic wr_ok;
   logic defaults_now;
   assign wr_ok = cs_rise & f_full;
   // soft power down or pin shutdown restores defaults
   assign defaults_now = ~pin_s2_r | ~opc_r[OPC_SOFT_PD];

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         main_r <= MAIN_RST;
         ref_r <= REF_RST;
         opc_r <= OPC_RST;
         setup_r <= SETUP_RST;
         test_r <= TEST_RST;
      end else if (wr_ok && pin_s2_r) begin
         // a write while soft power down is active still lands
         case (f_addr)
            ADDR_MAIN_DIV: main_r <= f_data[MAIN_W-1:0];
            ADDR_REF_DIV: ref_r <= f_data[REF_W-1:0];
            ADDR_OP_CTRL: opc_r <= f_data[OPC_W-1:0];
            ADDR_SETUP: setup_r <= f_data[SETUP_W-1:0];
            ADDR_TEST: test_r <= f_data[TEST_W-1:0];
            default: main_r <= main_r;
         endcase
      end else if (defaults_now) begin
         main_r <= MAIN_RST;
         ref_r <= REF_RST;
         opc_r <= OPC_RST;
         setup_r <= SETUP_RST;
         test_r <= TEST_RST;
      end
   end

   // error flag: last frame short or to an unknown address
   logic err_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         err_r <= 1'b0;
      end else if (cs_rise) begin
         case (f_addr)
            ADDR_MAIN_DIV, ADDR_REF_DIV, ADDR_OP_CTRL, ADDR_SETUP, ADDR_TEST:
               err_r <= ~f_full;
            default: err_r <= 1'b1;
         endcase
      end
   end

   // ****************************************
   // power state outputs
   // ****************************************
   logic core_r, pll_r, tx_r, boost_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         core_r <= 1'b0;
         pll_r <= 1'b0;
         tx_r <= 1'b0;
         boost_r <= 1'b0;
      end else begin
         core_r <= pin_s2_r & opc_r[OPC_SOFT_PD] & opc_r[OPC_STANDBY_KEEP_REGS_N];
         pll_r <= pin_s2_r & opc_r[OPC_SOFT_PD] & opc_r[OPC_STANDBY_KEEP_REGS_N]
                  & setup_r[SETUP_W-1];
         tx_r <= pin_s2_r & opc_r[OPC_SOFT_PD] & opc_r[OPC_STANDBY_KEEP_REGS_N]
                 & opc_r[OPC_TX_IDLE];
         boost_r <= opc_r[OPC_CP_BOOST];
      end
   end

   assign if_main_divide_ratio = main_r;
   assign if_reference_divide_ratio = ref_r;
   assign operation_control = opc_r;
   assign pll_and_input_setup = setup_r;
   assign test_mode_control = test_r;
   assign charge_pump_boost = boost_r;
   assign core_enable = core_r;
   assign pll_enable = pll_r;
   assign transmit_enable = tx_r;
   assign frame_error = err_r;

   // ****************************************
   // checks
   // ****************************************
   AST_LOAD_OPC: assert property (@(posedge mclk) disable iff (!rst_n)
      (wr_ok && pin_s2_r && f_addr == ADDR_OP_CTRL) |=> opc_r == $past(f_data[15:0]))
      else $error("op control not loaded");
   AST_LOAD_MAIN: assert property (@(posedge mclk) disable iff (!rst_n)
      (wr_ok && pin_s2_r && f_addr == ADDR_MAIN_DIV) |=> main_r == $past(f_data[13:0]))
      else $error("main divider not loaded");
   AST_LOAD_REF: assert property (@(posedge mclk) disable iff (!rst_n)
      (wr_ok && pin_s2_r && f_addr == ADDR_REF_DIV) |=> ref_r == $past(f_data[10:0]))
      else $error("ref divider not loaded");
   AST_BAD_ADDR: assert property (@(posedge mclk) disable iff (!rst_n)
      (wr_ok && f_addr == 4'h6 && !defaults_now) |=> $stable(opc_r) && $stable(main_r))
      else $error("undefined address changed state");
   AST_SOFT_PD: assert property (@(posedge mclk) disable iff (!rst_n)
      (!opc_r[OPC_SOFT_PD] && !wr_ok) |=> opc_r == OPC_RST && main_r == MAIN_RST)
      else $error("soft power down kept contents");
   AST_PIN_PD: assert property (@(posedge mclk) disable iff (!rst_n)
      (!pin_s2_r) |=> ref_r == REF_RST && test_r == TEST_RST && !core_r)
      else $error("pin shutdown kept contents");
   AST_STANDBY_KEEP_REGS_N: assert property (@(posedge mclk) disable iff (!rst_n)
      (!opc_r[OPC_STANDBY_KEEP_REGS_N] && opc_r[OPC_SOFT_PD] && pin_s2_r && !wr_ok)
      |=> $stable(setup_r) && !core_r)
      else $error("standby lost contents");
   AST_TX_IDLE: assert property (@(posedge mclk) disable iff (!rst_n)
      (!opc_r[OPC_TX_IDLE]) |=> !tx_r)
      else $error("transmit not idled");
   AST_BOOST: assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1 |=> charge_pump_boost == $past(opc_r[OPC_CP_BOOST]))
      else $error("boost mismatch");
   AST_SHORT: assert property (@(posedge mclk) disable iff (!rst_n)
      (cs_rise && !f_full && !defaults_now) |=> $stable(setup_r))
      else $error("short frame loaded");
   COV_OPC: cover property (@(posedge mclk) disable iff (!rst_n)
      wr_ok && f_addr == ADDR_OP_CTRL);
   COV_SETUP: cover property (@(posedge mclk) disable iff (!rst_n)
      wr_ok && f_addr == ADDR_SETUP);
   COV_SOFTPD: cover property (@(posedge mclk) disable iff (!rst_n)
      !opc_r[OPC_SOFT_PD]);
   COV_BAD: cover property (@(posedge mclk) disable iff (!rst_n)
      cs_rise && err_r == 1'b0 ##1 err_r);
   COV_PIN: cover property (@(posedge mclk) disable iff (!rst_n)
      !pin_s2_r ##1 pin_s2_r);

   // ****************************************
   // further load and hold checks
   // ****************************************
   AST_LOAD_SETUP: assert property (@(posedge mclk) disable iff (!rst_n)
      (wr_ok && pin_s2_r && f_addr == ADDR_SETUP)
      |=> setup_r == $past(f_data[15:0]))
      else $error("setup not loaded");
   AST_LOAD_TEST: assert property (@(posedge mclk) disable iff (!rst_n)
      (wr_ok && pin_s2_r && f_addr == ADDR_TEST)
      |=> test_r == $past(f_data[7:0]))
      else $error("test register not loaded");
   AST_IDLE_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
      (!wr_ok && !defaults_now)
      |=> $stable(main_r) && $stable(ref_r) && $stable(setup_r) && $stable(test_r))
      else $error("register changed without a frame");
   AST_IDLE_OPC: assert property (@(posedge mclk) disable iff (!rst_n)
      (!wr_ok && !defaults_now)
      |=> $stable(opc_r))
      else $error("op control changed without a frame");
   AST_BAD_ALL: assert property (@(posedge mclk) disable iff (!rst_n)
      (wr_ok && undef_addr && !defaults_now)
      |=> $stable(setup_r) && $stable(ref_r) && $stable(test_r))
      else $error("undefined address loaded a register");

   // ****************************************
   // shutdown and standby checks
   // ****************************************
   // pin shutdown wins over any frame that happens to complete
   AST_PIN_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
      (!pin_s2_r)
      |=> main_r == MAIN_RST && opc_r == OPC_RST && setup_r == SETUP_RST)
      else $error("pin shutdown let a register change");
   AST_PIN_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
      (!pin_s2_r)
      |=> !pll_r && !tx_r)
      else $error("pin shutdown left a function on");
   AST_SOFT_REL: assert property (@(posedge mclk) disable iff (!rst_n)
      (!opc_r[OPC_SOFT_PD] && !wr_ok)
      |=> opc_r[OPC_SOFT_PD])
      else $error("soft power down did not release");
   AST_SOFT_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
      (!opc_r[OPC_SOFT_PD])
      |=> !core_r && !pll_r && !tx_r)
      else $error("soft power down left a function on");
   AST_SOFT_REST: assert property (@(posedge mclk) disable iff (!rst_n)
      (!opc_r[OPC_SOFT_PD] && !wr_ok)
      |=> ref_r == REF_RST && setup_r == SETUP_RST && test_r == TEST_RST)
      else $error("soft power down kept programmed values");
   AST_STANDBY_KEEP_REGS_N_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
      (!opc_r[OPC_STANDBY_KEEP_REGS_N])
      |=> !pll_r && !tx_r)
      else $error("standby left a function on");
   AST_STANDBY_KEEP_REGS_N_KEEP: assert property (@(posedge mclk) disable iff (!rst_n)
      (!opc_r[OPC_STANDBY_KEEP_REGS_N] && opc_r[OPC_SOFT_PD] && pin_s2_r && !wr_ok)
      |=> $stable(main_r) && $stable(ref_r) && $stable(test_r))
      else $error("standby lost divider contents");

   // ****************************************
   // enable and error flag checks
   // ****************************************
   AST_CORE_ON: assert property (@(posedge mclk) disable iff (!rst_n)
      (pin_s2_r && opc_r[OPC_SOFT_PD] && opc_r[OPC_STANDBY_KEEP_REGS_N])
      |=> core_r)
      else $error("core not enabled");
   AST_TX_ON: assert property (@(posedge mclk) disable iff (!rst_n)
      (pin_s2_r && opc_r[OPC_SOFT_PD] && opc_r[OPC_STANDBY_KEEP_REGS_N] && opc_r[OPC_TX_IDLE])
      |=> tx_r)
      else $error("transmit not enabled");
   AST_PLL_SET: assert property (@(posedge mclk) disable iff (!rst_n)
      (!setup_r[SETUP_W-1])
      |=> !pll_r)
      else $error("pll on while setup turns it off");
   AST_ERR_UNDEF: assert property (@(posedge mclk) disable iff (!rst_n)
      (cs_rise && undef_addr)
      |=> err_r)
      else $error("undefined address not flagged");
   AST_ERR_SHORT: assert property (@(posedge mclk) disable iff (!rst_n)
      (cs_rise && !f_full)
      |=> err_r)
      else $error("short frame not flagged");
   AST_ERR_OK: assert property (@(posedge mclk) disable iff (!rst_n)
      (cs_rise && f_full && !undef_addr)
      |=> !err_r)
      else $error("good frame flagged");
   // the flag stands between frames so a slow reader still sees it
   AST_ERR_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
      (!cs_rise)
      |=> $stable(err_r))
      else $error("error flag moved between frames");
   AST_CS_ONE: assert property (@(posedge mclk) disable iff (!rst_n)
      cs_rise
      |=> !cs_rise)
      else $error("one chip select rise loaded twice");
endmodule
`default_nettype wire

/* File: testbench/twcrl_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// serial host model, sclk still outside frames
// ****************************************
module twcrl_host (
   output logic sclk,
   output logic cs_n,
   output logic sdata
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdata = 1'b0;
   end
   // sends the low n bits of frame, msb first, so the address goes last
   task automatic send(input logic [31:0] frame, input int n);
      #7;
      cs_n <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         sdata <= frame[i];
         #62.5 sclk <= 1'b1;
         #62.5 sclk <= 1'b0;
      end
      #62.5 cs_n <= 1'b1;
      // released line shows the inverse, never a stale bit
      sdata <= ~sdata;
      #100;
   endtask
endmodule
`default_nettype wire

/* File: testbench/tb_three_wire_control_register_loader.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
   $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_three_wire_control_register_loader;
   import twcrl_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic shutdown_pin_n = 1'b1;
   wire sclk, cs_n, sdata;
   logic [13:0] main_q;
   logic [10:0] ref_q;
   logic [15:0] opc_q, setup_q;
   logic [7:0] test_q;
   logic boost_q, core_q, pll_q, tx_q, ferr_q;
   int errors = 0;
   int check_count = 0;
   logic [15:0] opc_tab [3] = '{16'h892b, 16'h892d, 16'ha92f};
   always #10 mclk = ~mclk;
   twcrl_host host_u (.sclk(sclk), .cs_n(cs_n), .sdata(sdata));
   twcrl_loader dut_u (.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
      .sdata(sdata), .shutdown_pin_n(shutdown_pin_n), .if_main_divide_ratio(main_q),
      .if_reference_divide_ratio(ref_q), .operation_control(opc_q),
      .pll_and_input_setup(setup_q), .test_mode_control(test_q),
      .charge_pump_boost(boost_q), .core_enable(core_q), .pll_enable(pll_q),
      .transmit_enable(tx_q), .frame_error(ferr_q));
   // ****************************************
   // helpers
   // ****************************************
   task automatic settle();
      repeat (8) @(posedge mclk);
   endtask
   task automatic wr(input logic [19:0] d, input logic [3:0] a);
      host_u.send({8'h00, d, a}, 24);
      settle();
   endtask
   task automatic chk_defaults();
      `CHK(main_q, MAIN_RST)
      `CHK(ref_q, REF_RST)
      `CHK(opc_q, OPC_RST)
      `CHK(setup_q, SETUP_RST)
      `CHK(test_q, TEST_RST)
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      settle();
      chk_defaults();
      `CHK({core_q, pll_q, tx_q}, 3'b111)
      $display("test defaults done");
      wr(20'hfc3ef, ADDR_MAIN_DIV);
      `CHK(main_q, 14'h03ef)
      wr(20'hff836, ADDR_REF_DIV);
      `CHK(ref_q, 11'h036)
      wr(20'hf903d, ADDR_SETUP);
      `CHK(setup_q, 16'h903d)
      wr(20'hfff5a, ADDR_TEST);
      `CHK(test_q, 8'h5a)
      $display("test register writes done");
      wr(20'h12345, 4'h6);
      `CHK(ferr_q, 1'b1)
      `CHK(main_q, 14'h03ef)
      host_u.send({20'h00111, ADDR_MAIN_DIV}, 23);
      settle();
      `CHK(main_q, 14'h03ef)
      host_u.send({1'b1, 20'h00abc, ADDR_MAIN_DIV}, 25);
      settle();
      `CHK(main_q, 14'h0abc)
      `CHK(ferr_q, 1'b0)
      $display("test framing done");
      for (int i = 0; i < 3; i++) begin
         wr({4'hf, opc_tab[i]}, ADDR_OP_CTRL);
         `CHK(opc_q, opc_tab[i])
         `CHK(core_q, opc_tab[i][0] & opc_tab[i][2])
         `CHK(tx_q, opc_tab[i][0] & opc_tab[i][2] & opc_tab[i][1])
         `CHK(boost_q, opc_tab[i][13])
         `CHK(main_q, 14'h0abc)
      end
      $display("test control bits done");
      wr(20'h0890e, ADDR_OP_CTRL);
      chk_defaults();
      wr(20'h003ef, ADDR_MAIN_DIV);
      `CHK(main_q, 14'h03ef)
      $display("test soft power down done");
      shutdown_pin_n <= 1'b0;
      settle();
      chk_defaults();
      `CHK({core_q, pll_q, tx_q}, 3'b000)
      wr(20'h00111, ADDR_MAIN_DIV);
      @(posedge mclk) shutdown_pin_n <= 1'b1;
      settle();
      `CHK(main_q, MAIN_RST)
      $display("test shutdown pin done");
      final_report();
   end
   initial begin
      #400us;
      errors++;
      final_report();
   end
endmodule
`default_nettype wire
